// *** verilog/sram_pkg.sv ***
// shared constants, types and helpers for the burst SRAM bus and both ends
// What this block does
// - device registers all synchronous inputs on rising edge
// - qualifier high makes device ignore the edge
// - back-to-back reads and writes, no wait states
// - controller starts writes with write strobe low
// - active-low byte lanes pick written bytes
// - writes complete internally, no extra pulse needed
// - device tri-states outputs during write data
// - a load selects only when cs1 low, cs2 high, cs3 low; advance beats ignore the selects
// - sampled address picks one of 256K words
// - low two address bits seed burst counter
// - advance high on qualified edge steps burst
// - advance low on qualified edge loads address
// - controller loads fresh address after a deselect
// - array is 256K words of 32 bits, shared bus
// - inputs registered, read data flows through unregistered
// - burst order linear or interleaved by strap
// - chip selects and async output enable gate drive
// - drive only on reads with output enable low
// - strap low linear, high interleaved; no pull, so an open strap is not resolved
// - qualifier high never deselects, just stretches cycle
package sram_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int LANE_N = 4;
    localparam int LANE_W = 8;
    localparam int WORDS = 262144;
    localparam int BEAT_W = 2;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
    localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
    localparam logic [LANE_N-1:0] LANES_OFF = 4'hf;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {op_idle, op_read, op_write, op_next} op_e;

    // replace only the bytes whose active-low lane strobe is low
    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [LANE_N-1:0] lanes_n
    );
        logic [DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < LANE_N; i++)
        begin
            if (!lanes_n[i])
            begin
                res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction
endpackage

// *** verilog/sram_bus_if.sv ***
// pin-level bus between the memory controller and the burst SRAM
`timescale 1ns/1ns
interface sram_bus_if;
    logic clock_qualify_n;
    logic cs1_n;
    logic cs2;
    logic cs3_n;
    logic write_n;
    logic advance_or_load;
    logic oe_n;
    logic [sram_pkg::LANE_N-1:0] byte_lane_write_n;
    logic [sram_pkg::ADDR_W-1:0] addr;
    logic [sram_pkg::DATA_W-1:0] ctl_dq_out;
    logic ctl_dq_oe;
    logic [sram_pkg::DATA_W-1:0] dev_dq_out;
    logic dev_dq_oe;
    wire [sram_pkg::DATA_W-1:0] dq;

    // resolved shared data wire; both enables high is a contention fault
    // no pull on the bus: a free bus reads as zeros, the enables tell who drives
    assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : sram_pkg::DATA_RST);

    modport dev(
        input clock_qualify_n, cs1_n, cs2, cs3_n, write_n, advance_or_load, oe_n,
        input byte_lane_write_n, addr, dq,
        output dev_dq_out, dev_dq_oe
    );
    modport ctl(
        output clock_qualify_n, cs1_n, cs2, cs3_n, write_n, advance_or_load, oe_n,
        output byte_lane_write_n, addr, ctl_dq_out, ctl_dq_oe,
        input dq
    );
endinterface

// *** verilog/burst_addr_gen.sv ***
// low address bits of a four-word burst beat
`timescale 1ns/1ns
module burst_addr_gen (
    // burst state
    input wire logic [sram_pkg::BEAT_W-1:0] start_low,
    input wire logic [sram_pkg::BEAT_W-1:0] beat,
    input wire logic linear,
    // result
    output logic [sram_pkg::BEAT_W-1:0] addr_low
);
    // both orders wrap inside the aligned four-word block
    assign addr_low = linear ? sram_pkg::BEAT_W'(start_low + beat) : (start_low ^ beat);
endmodule

// *** verilog/sram_device.sv ***
// synchronous flow-through burst SRAM end of the bus
`timescale 1ns/1ns
module sram_device (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // memory bus pins
    sram_bus_if.dev bus,
    // burst order strap, low selects linear
    input wire logic burst_order_strap,
    // status
    output logic burst_linear,
    output logic selected,
    output logic write_pending
);
    localparam int AW = sram_pkg::ADDR_W;
    localparam int DW = sram_pkg::DATA_W;
    localparam int BW = sram_pkg::BEAT_W;

    logic [DW-1:0] mem [0:sram_pkg::WORDS-1];

    logic qual;
    logic chip_sel;
    logic active;
    logic burst_write;
    logic [AW-1:BW] base_addr;
    logic [BW-1:0] start_low;
    logic [BW-1:0] beat;
    logic [BW-1:0] step_beat;
    logic [BW-1:0] adv_low;
    logic next_valid;
    logic next_write;
    logic [AW-1:0] next_addr;
    logic [sram_pkg::LANE_N-1:0] next_lanes_n;
    logic wr_pend;
    logic [AW-1:0] wr_addr;
    logic [sram_pkg::LANE_N-1:0] wr_lanes_n;
    logic dq_drive;
    logic [DW-1:0] dq_out_r;
    logic [DW-1:0] read_word;
    logic strap_meta;
    logic strap_sync;
    logic [1:0] strap_cnt;
    logic strap_done;

    // the edge counts only while the qualifier is low
    assign qual = !bus.clock_qualify_n;

    assign chip_sel = !bus.cs1_n && bus.cs2 && !bus.cs3_n;

    assign step_beat = BW'(beat + sram_pkg::BEAT_STEP);

    burst_addr_gen u_burst (
        .start_low(start_low),
        .beat(step_beat),
        .linear(burst_linear),
        .addr_low(adv_low)
    );

    // access decoded from the pins at this edge
    always_comb
    begin
        next_valid = 1'b0;
        next_write = 1'b0;
        next_addr = sram_pkg::ADDR_RST;
        next_lanes_n = sram_pkg::LANES_OFF;
        if (!bus.advance_or_load)
        begin
            next_valid = chip_sel;
            next_write = chip_sel && !bus.write_n;
            next_addr = bus.addr;
        end
        else
        begin
            // advance keeps the open burst going, selects are not looked at
            next_valid = active;
            next_write = active && burst_write;
            next_addr = {base_addr, adv_low};
        end
        if (next_write)
        begin
            next_lanes_n = bus.byte_lane_write_n;
        end
    end

    // burst counter and open-burst state
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            active <= 1'b0;
            burst_write <= 1'b0;
            base_addr <= sram_pkg::ADDR_RST[AW-1:BW];
            start_low <= sram_pkg::BEAT_RST;
            beat <= sram_pkg::BEAT_RST;
        end
        else if (qual)
        begin
            if (!bus.advance_or_load)
            begin
                active <= chip_sel;
                burst_write <= !bus.write_n;
                base_addr <= bus.addr[AW-1:BW];
                start_low <= bus.addr[BW-1:0];
                beat <= sram_pkg::BEAT_RST;
            end
            else if (active)
            begin
                beat <= step_beat;
            end
        end
    end

    // write command waits one qualified cycle for its data
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_pend <= 1'b0;
            wr_addr <= sram_pkg::ADDR_RST;
            wr_lanes_n <= sram_pkg::LANES_OFF;
        end
        else if (qual)
        begin
            wr_pend <= next_write;
            wr_addr <= next_addr;
            wr_lanes_n <= next_lanes_n;
        end
    end

    // self-timed commit: the data edge is the whole write
    always_ff @(posedge ref_clk)
    begin
        if (qual && wr_pend)
        begin
            mem[wr_addr] <= sram_pkg::merge_lanes(mem[wr_addr], bus.dq, wr_lanes_n);
        end
    end

    // a read right behind a write to the same word must see the new bytes
    always_comb
    begin
        read_word = mem[next_addr];
        if (wr_pend && (wr_addr == next_addr))
        begin
            read_word = sram_pkg::merge_lanes(read_word, bus.dq, wr_lanes_n);
        end
    end

    // read data leaves the array in the cycle after the address edge,
    // with no extra output stage in between
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dq_out_r <= sram_pkg::DATA_RST;
        end
        else if (qual)
        begin
            dq_out_r <= read_word;
        end
    end

    // drive only after a read beat; writes, deselect and the cycle that
    // follows a deselect all leave the bus free
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dq_drive <= 1'b0;
        end
        else if (qual)
        begin
            dq_drive <= next_valid && !next_write;
        end
    end

    // output enable acts without the clock on purpose
    assign bus.dev_dq_oe = dq_drive && !bus.oe_n;
    assign bus.dev_dq_out = dq_out_r;

    // strap is a pin: synchronise, let it settle, then freeze it
    always_ff @(posedge ref_clk)
    begin
        strap_meta <= burst_order_strap;
        strap_sync <= strap_meta;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            burst_linear <= 1'b0;
        end
        else if (!strap_done)
        begin
            if (strap_cnt == sram_pkg::STRAP_SETTLE)
            begin
                burst_linear <= !strap_sync;
                strap_done <= 1'b1;
            end
            else
            begin
                strap_cnt <= 2'(strap_cnt + 2'h1);
            end
        end
    end

    // status for the user side
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            selected <= 1'b0;
            write_pending <= 1'b0;
        end
        else if (qual)
        begin
            selected <= next_valid;
            write_pending <= next_write;
        end
    end
endmodule

// *** verilog/sram_controller.sv ***
// memory controller end of the burst SRAM bus
`timescale 1ns/1ns
module sram_controller (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // memory bus pins
    sram_bus_if.ctl bus,
    // command side
    input wire logic suspend,
    input wire sram_pkg::op_e cmd_op,
    input wire logic [sram_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [sram_pkg::LANE_N-1:0] cmd_lanes_n,
    input wire logic [sram_pkg::DATA_W-1:0] cmd_wdata,
    // read return
    output logic rd_valid,
    output logic [sram_pkg::DATA_W-1:0] rd_data
);
    logic beat_read;
    logic beat_write;
    logic [sram_pkg::DATA_W-1:0] beat_wdata;
    logic deselected;
    logic burst_is_write;
    logic rd_pend;
    logic pin_qual;

    // the device acts on an edge only if the pins then carried qualifier low
    assign pin_qual = !bus.clock_qualify_n;

    // command pins, one command per edge unless suspended
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bus.clock_qualify_n <= 1'b1;
            bus.cs1_n <= 1'b1;
            bus.cs2 <= 1'b0;
            bus.cs3_n <= 1'b1;
            bus.write_n <= 1'b1;
            bus.advance_or_load <= 1'b0;
            bus.oe_n <= 1'b1;
            bus.byte_lane_write_n <= sram_pkg::LANES_OFF;
            bus.addr <= sram_pkg::ADDR_RST;
            beat_read <= 1'b0;
            beat_write <= 1'b0;
            beat_wdata <= sram_pkg::DATA_RST;
            deselected <= 1'b1;
            burst_is_write <= 1'b0;
        end
        else
        begin
            bus.clock_qualify_n <= suspend;
            bus.oe_n <= 1'b0;
            if (!suspend)
            begin
                beat_wdata <= cmd_wdata;
                bus.byte_lane_write_n <= sram_pkg::LANES_OFF;
                case (cmd_op)
                    sram_pkg::op_read, sram_pkg::op_write:
                    begin
                        bus.cs1_n <= 1'b0;
                        bus.cs2 <= 1'b1;
                        bus.cs3_n <= 1'b0;
                        bus.advance_or_load <= 1'b0;
                        bus.addr <= cmd_addr;
                        bus.write_n <= (cmd_op != sram_pkg::op_write);
                        if (cmd_op == sram_pkg::op_write)
                        begin
                            bus.byte_lane_write_n <= cmd_lanes_n;
                        end
                        beat_read <= (cmd_op == sram_pkg::op_read);
                        beat_write <= (cmd_op == sram_pkg::op_write);
                        burst_is_write <= (cmd_op == sram_pkg::op_write);
                        deselected <= 1'b0;
                    end
                    sram_pkg::op_next:
                    begin
                        // no open burst to advance: fall back to deselect
                        bus.advance_or_load <= !deselected;
                        bus.cs1_n <= deselected;
                        if (burst_is_write && !deselected)
                        begin
                            bus.byte_lane_write_n <= cmd_lanes_n;
                        end
                        beat_read <= !deselected && !burst_is_write;
                        beat_write <= !deselected && burst_is_write;
                    end
                    default:
                    begin
                        bus.cs1_n <= 1'b1;
                        bus.advance_or_load <= 1'b0;
                        bus.write_n <= 1'b1;
                        beat_read <= 1'b0;
                        beat_write <= 1'b0;
                        deselected <= 1'b1;
                    end
                endcase
            end
        end
    end

    // data phase follows the command by one qualified edge
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bus.ctl_dq_oe <= 1'b0;
            bus.ctl_dq_out <= sram_pkg::DATA_RST;
            rd_pend <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= sram_pkg::DATA_RST;
        end
        else
        begin
            rd_valid <= 1'b0;
            if (pin_qual)
            begin
                bus.ctl_dq_oe <= beat_write;
                bus.ctl_dq_out <= beat_wdata;
                rd_pend <= beat_read;
                rd_valid <= rd_pend;
                if (rd_pend)
                begin
                    rd_data <= bus.dq;
                end
            end
        end
    end
endmodule

// *** tb/sram_bus_asserts.sv ***
// concurrent checks on the burst SRAM bus between both ends
`timescale 1ns/1ns
module sram_bus_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // bus signals
    input wire logic clock_qualify_n,
    input wire logic cs1_n,
    input wire logic cs2,
    input wire logic cs3_n,
    input wire logic write_n,
    input wire logic advance_or_load,
    input wire logic oe_n,
    input wire logic ctl_dq_oe,
    input wire logic [sram_pkg::DATA_W-1:0] dev_dq_out,
    input wire logic dev_dq_oe
);
    logic sel;
    logic load;
    logic adv;
    logic burst_open;
    logic burst_wr;
    assign sel = !cs1_n && cs2 && !cs3_n;
    assign load = !clock_qualify_n && !advance_or_load;
    assign adv = !clock_qualify_n && advance_or_load;
    // mirror of the open burst, since write strobe is ignored on advance beats
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            burst_open <= 1'b0;
            burst_wr <= 1'b0;
        end
        else if (load)
        begin
            burst_open <= sel;
            burst_wr <= !write_n;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence rd_beat;
        (load && sel && write_n) || (adv && burst_open && !burst_wr);
    endsequence
    sequence wr_beat;
        (load && sel && !write_n) || (adv && burst_open && burst_wr);
    endsequence
    a_read_flows: assert property (rd_beat |=> dev_dq_oe == !oe_n)
        else $error("read beat did not drive data");
    a_write_data_phase: assert property (wr_beat |=> !dev_dq_oe && ctl_dq_oe)
        else $error("write data phase not owned by controller");
    a_deselect_quiet: assert property (load && !sel |=> !dev_dq_oe)
        else $error("device drove while deselected");
    a_adv_closed: assert property (adv && !burst_open |=> !dev_dq_oe)
        else $error("advance without open burst drove bus");
    a_load_after_desel: assert property (!clock_qualify_n && !burst_open |-> !advance_or_load)
        else $error("controller advanced with no open burst");
    a_oe_masks: assert property (oe_n |-> !dev_dq_oe)
        else $error("drive with output enable high");
    a_no_contention: assert property (!(dev_dq_oe && ctl_dq_oe))
        else $error("both ends drive data");
    a_suspend_holds: assert property (clock_qualify_n |=> $stable(dev_dq_out) && $stable(dev_dq_oe))
        else $error("device moved on an ignored edge");
    a_reset_idle: assert property (disable iff (1'b0) rst |=> !dev_dq_oe && !ctl_dq_oe && !sel)
        else $error("bus not idle in reset");
endmodule

// *** tb/sync_flowthrough_burst_sram_test.sv ***
// self-checking bench joining controller and device over the bus
`timescale 1ns/1ns
module sync_flowthrough_burst_sram_test;
    logic ref_clk;
    logic rst;
    logic strap;
    logic suspend;
    sram_pkg::op_e cmd_op;
    logic [sram_pkg::ADDR_W-1:0] cmd_addr;
    logic [sram_pkg::LANE_N-1:0] cmd_lanes_n;
    logic [sram_pkg::DATA_W-1:0] cmd_wdata;
    logic rd_valid;
    logic [sram_pkg::DATA_W-1:0] rd_data;
    logic burst_linear;
    logic dev_selected;
    logic dev_write_pending;
    int errors;
    int num_checks;
    int cycles;
    sram_bus_if bus ();
    sram_device u_sram_device (.ref_clk(ref_clk), .rst(rst), .bus(bus.dev),
        .burst_order_strap(strap), .burst_linear(burst_linear), .selected(dev_selected),
        .write_pending(dev_write_pending));
    sram_controller u_sram_controller (.ref_clk(ref_clk), .rst(rst), .bus(bus.ctl),
        .suspend(suspend), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_lanes_n(cmd_lanes_n),
        .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data));
    sram_bus_asserts u_sram_bus_asserts (.ref_clk(ref_clk), .rst(rst),
        .clock_qualify_n(bus.clock_qualify_n), .cs1_n(bus.cs1_n), .cs2(bus.cs2),
        .cs3_n(bus.cs3_n), .write_n(bus.write_n), .advance_or_load(bus.advance_or_load),
        .oe_n(bus.oe_n), .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_out(bus.dev_dq_out),
        .dev_dq_oe(bus.dev_dq_oe));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // tests take under two hundred cycles; the ceiling at 5000 leaves wide margin
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            print_verdict;
        end
    end

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmd(input sram_pkg::op_e op, input logic [17:0] a, input logic [3:0] ln,
        input logic [31:0] d);
        @(posedge ref_clk);
        #2;
        cmd_op = op;
        cmd_addr = a;
        cmd_lanes_n = ln;
        cmd_wdata = d;
    endtask

    task automatic wait_rd(input logic [31:0] exp);
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (rd_valid !== 1'b1 && n < 10);
        check_eq({31'h0, rd_valid}, 32'h1, "read return");
        check_eq(rd_data, exp, "read data");
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] exp);
        cmd(sram_pkg::op_read, a, 4'hf, 32'h0);
        cmd(sram_pkg::op_idle, a, 4'hf, 32'h0);
        wait_rd(exp);
    endtask

    task automatic t_lanes;
        cmd(sram_pkg::op_write, 18'h00011, 4'h0, 32'h5a5a0f0f);
        cmd(sram_pkg::op_write, 18'h00010, 4'h0, 32'h11223344);
        cmd(sram_pkg::op_write, 18'h00010, 4'ha, 32'haabbccdd);
        cmd(sram_pkg::op_read, 18'h00010, 4'hf, 32'h0);
        check_eq({30'h0, dev_selected, dev_write_pending}, 32'h3, "write status");
        cmd(sram_pkg::op_read, 18'h00011, 4'hf, 32'h0);
        cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        check_eq({30'h0, dev_selected, dev_write_pending}, 32'h2, "read status");
        wait_rd(32'h11bb33dd);
        @(posedge ref_clk);
        #1;
        check_eq({31'h0, rd_valid}, 32'h1, "second read");
        check_eq(rd_data, 32'h5a5a0f0f, "second data");
        $display("test lanes done");
    endtask

    task automatic t_bounds;
        cmd(sram_pkg::op_write, 18'h3ffff, 4'h0, 32'hfeedf00d);
        cmd(sram_pkg::op_write, 18'h00000, 4'h0, 32'h0badcafe);
        rd(18'h3ffff, 32'hfeedf00d);
        rd(18'h00000, 32'h0badcafe);
        $display("test bounds done");
    endtask

    task automatic t_suspend;
        cmd(sram_pkg::op_write, 18'h00020, 4'h0, 32'h0000aaaa);
        cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        cmd(sram_pkg::op_write, 18'h00020, 4'h0, 32'h0000bbbb);
        suspend = 1'b1;
        cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        suspend = 1'b0;
        rd(18'h00020, 32'h0000aaaa);
        cmd(sram_pkg::op_read, 18'h00020, 4'hf, 32'h0);
        cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        suspend = 1'b1;
        repeat (2) cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        suspend = 1'b0;
        wait_rd(32'h0000aaaa);
        $display("test suspend done");
    endtask

    task automatic t_deselect;
        repeat (2) cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        check_eq({30'h0, bus.dev_dq_oe, bus.ctl_dq_oe}, 32'h0, "idle bus");
        check_eq({30'h0, dev_selected, dev_write_pending}, 32'h0, "idle status");
        cmd(sram_pkg::op_next, 18'h00010, 4'hf, 32'h0);
        cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        // the advance asked for after a deselect must reach the pins as a load
        check_eq({30'h0, bus.advance_or_load, bus.cs1_n}, 32'h1, "load after deselect");
        cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        check_eq({30'h0, bus.dev_dq_oe, bus.ctl_dq_oe}, 32'h0, "advance deselected");
        rd(18'h00010, 32'h11bb33dd);
        $display("test deselect done");
    endtask

    task automatic t_burst(input logic s, input logic [1:0] start);
        logic [1:0] lo;
        #1;
        strap = s;
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        #2;
        check_eq({31'h0, burst_linear}, {31'h0, !s}, "burst order");
        cmd(sram_pkg::op_write, {16'h0123, start}, 4'h0, 32'hb0000000);
        for (int n = 1; n < 4; n++)
            cmd(sram_pkg::op_next, 18'h00000, 4'h0, 32'hb0000000 + n);
        cmd(sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
        // read burst: beat n returns on the pin cycle after command n + 3
        cmd(sram_pkg::op_read, {16'h0123, start}, 4'hf, 32'h0);
        for (int n = 1; n < 7; n++)
        begin
            cmd((n < 4) ? sram_pkg::op_next : sram_pkg::op_idle, 18'h00000, 4'hf, 32'h0);
            if (n >= 3)
            begin
                check_eq({31'h0, rd_valid}, 32'h1, "burst read return");
                check_eq(rd_data, 32'hb0000000 + n - 3, "burst read data");
            end
        end
        for (int n = 0; n < 4; n++)
        begin
            lo = s ? (start ^ n[1:0]) : (start + n[1:0]);
            rd({16'h0123, lo}, 32'hb0000000 + n);
        end
        $display("test burst done");
    endtask

    initial
    begin
        errors = 0;
        num_checks = 0;
        cycles = 0;
        rst = 1'b1;
        strap = 1'b0;
        suspend = 1'b0;
        cmd_op = sram_pkg::op_idle;
        cmd_addr = 18'h00000;
        cmd_lanes_n = 4'hf;
        cmd_wdata = 32'h00000000;
        repeat (8) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        t_lanes;
        t_bounds;
        t_suspend;
        t_deselect;
        t_burst(1'b0, 2'h2);
        t_burst(1'b1, 2'h1);
        print_verdict;
    end
endmodule
